// ===== inc/acms_pkg.sv
package acms_pkg;

    // Register bus geometry
    localparam int unsigned APB_ADDR_W = 8;
    localparam int unsigned APB_DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK   = 8'h08;
    localparam logic [7:0] OFS_DATA   = 8'h0C;
    localparam logic [7:0] OFS_CALIB  = 8'h10;

    // Control register fields
    localparam int unsigned CTRL_MODE_LSB  = 0;
    localparam int unsigned CTRL_NOTCH_LSB = 2;
    localparam int unsigned CTRL_GAIN_LSB  = 4;
    localparam int unsigned CTRL_USED_W    = 6;
    localparam logic [5:0]  CTRL_RESET     = 6'h00;

    // Operating mode codes held in the two mode bits
    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_SELF_CAL = 2'h1;
    localparam logic [1:0] MODE_ZS_SYS   = 2'h2;
    localparam logic [1:0] MODE_FS_SYS   = 2'h3;

    // Gain codes: gains of 1, 2, 32 and 128
    localparam logic [1:0] GAIN_X1   = 2'h0;
    localparam logic [1:0] GAIN_X2   = 2'h1;
    localparam logic [1:0] GAIN_X32  = 2'h2;
    localparam logic [1:0] GAIN_X128 = 2'h3;

    // Input sampling divisors: master clock / 64, times 1, 2, 8, 8
    localparam logic [15:0] SAMPLE_DIV_X1  = 16'h0040;
    localparam logic [15:0] SAMPLE_DIV_X2  = 16'h0020;
    localparam logic [15:0] SAMPLE_DIV_HI  = 16'h0008;

    // Output periods per calibration phase
    localparam logic [3:0] CAL_TICKS_SELF  = 4'h6;
    localparam logic [3:0] DATA_READY_N_TICKS_SELF = 4'h9;
    localparam logic [3:0] CAL_TICKS_SYS   = 4'h3;
    localparam logic [3:0] DATA_READY_N_TICKS_SYS  = 4'h4;
    localparam logic [3:0] ZS_PHASE_TICKS  = 4'h3;

    // Pipeline delay after the first conversion, in master clock periods
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned PIPE_DELAY_MCLK = 2000;
    localparam int unsigned PIPE_CYCLES     = PIPE_DELAY_MCLK;
    localparam int unsigned PIPE_W          = 11;

    // Event bits of the status and mask registers
    localparam int unsigned EVT_W        = 2;
    localparam int unsigned EVT_DATA_RDY = 0;
    localparam int unsigned EVT_CAL_DONE = 1;
    localparam logic [1:0]  MASK_RESET   = 2'h0;

    // Result width
    localparam int unsigned RES_W = 16;

    typedef enum logic [1:0] {ST_RUN, ST_CAL, ST_CONV, ST_PIPE} acms_state_type;

endpackage

// ===== src/acms_rate_div.sv
`timescale 1ns/10ps
`default_nettype none
module acms_rate_div
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        restart,
    input  wire logic [15:0] divisor,
    output var  logic        tick
);

    logic [15:0] countReg;

    // Counts master clocks and restarts on request or at the period end
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            countReg <= 16'h0000;
        end
        else if (restart || (countReg >= divisor - 16'h0001))
        begin
            countReg <= 16'h0000;
        end
        else
        begin
            countReg <= countReg + 16'h0001;
        end
    end

    // One-cycle pulse at the last clock of every period
    always_comb
    begin
        tick = !restart && (countReg >= divisor - 16'h0001);
    end

endmodule
`default_nettype wire

// ===== src/acms_irq_status.sv
`timescale 1ns/10ps
`default_nettype none
module acms_irq_status
(
    input  wire logic                      mclk,
    input  wire logic                      reset_n,
    input  wire logic [acms_pkg::EVT_W-1:0] evtSet,
    input  wire logic                      rdClear,
    input  wire logic [acms_pkg::EVT_W-1:0] maskVal,
    output var  logic [acms_pkg::EVT_W-1:0] status_reg,
    output var  logic                      irq
);

    // Sticky bits; an event in the clearing cycle survives
    for (genvar i = 0; i < acms_pkg::EVT_W; i++)
    begin : g_evt
        always_ff @(posedge mclk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                status_reg[i] <= 1'b0;
            end
            else if (evtSet[i])
            begin
                status_reg[i] <= 1'b1;
            end
            else if (rdClear)
            begin
                status_reg[i] <= 1'b0;
            end
        end
    end

    // Level interrupt while any unmasked bit is set
    always_comb
    begin
        irq = |(status_reg & maskVal);
    end

endmodule
`default_nettype wire

// ===== src/acms_sequencer.sv
// How it works
// (R1) Data-ready falls when calibration sequence ends
// (R2) Post-calibration sample comes from automatic conversion
// (R3) Mode bits clear to normal after calibration
// (R4) Host: mode clear does not mean data
// (R5) Data-ready adds conversion plus pipeline delay
// (R6) Code 01: self cal, 6 then 9
// (R7) Code 10: zero-scale system, 3 then 4
// (R8) Code 11: full-scale system, 3 then 4
// (R9) Output register refreshed once per output period
// (R10) Host reads no faster than update rate
// (R11) Notch select sets first notch frequency
// (R12) Notch frequency scales with master clock
// (R13) Four gains: 1, 2, 32, 128
// (R14) Continuous sampling from clock, scaled by gain
// (R15) Host may tie chip select low
// (R16) Data-ready stays high during calibration
`timescale 1ns/10ps
`default_nettype none
module acms_sequencer
#(
    parameter int unsigned NOTCH_DIV_0 = 49152,
    parameter int unsigned NOTCH_DIV_1 = 40960,
    parameter int unsigned NOTCH_DIV_2 = 9830,
    parameter int unsigned NOTCH_DIV_3 = 4915
)
(
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic [15:0]            filterWord,
    output var  logic                   data_ready_n,
    output var  logic                   sampleStrobe,
    output var  logic [1:0]             gainCode,
    output var  logic                   zeroScale,
    output var  logic                   fullScale,
    output var  logic                   irq
);

    acms_pkg::acms_state_type state_reg;
    acms_pkg::acms_state_type state_next;

    logic [1:0]                    mode_reg;
    logic [1:0]                    notch_reg;
    logic [1:0]                    gain_reg;
    logic [acms_pkg::EVT_W-1:0]    mask_reg;
    logic [acms_pkg::EVT_W-1:0]    status_reg;
    logic [acms_pkg::RES_W-1:0]    result_reg;
    logic [acms_pkg::RES_W-1:0]    offset_reg;
    logic [acms_pkg::RES_W-1:0]    full_reg;
    logic [3:0]                    tick_reg;
    logic [acms_pkg::PIPE_W-1:0]   pipe_reg;
    logic                          drdyN_reg;
    logic [31:0]                   prdata_reg;
    logic                          zs_reg;
    logic                          fs_reg;
    logic [1:0]                    calCode_reg;
    logic                          wrAccess;
    logic                          setupRead;
    logic                          calStart;
    logic                          outTick;
    logic                          sampleTick;
    logic [15:0]                   notchDiv;
    logic [15:0]                   sampleDiv;
    logic [3:0]                    calTicks;
    logic [3:0]                    drdyTicks;
    logic                          calEnd;
    logic                          convEnd;
    logic                          pipeEnd;
    logic                          zsPhaseEnd;
    logic                          newResult;
    logic [acms_pkg::EVT_W-1:0]    evtSet;

    // Tells whether a byte offset maps to a register
    function automatic logic isMapped(input logic [7:0] addr);
        isMapped = (addr == acms_pkg::OFS_CTRL) || (addr == acms_pkg::OFS_STATUS)
                || (addr == acms_pkg::OFS_MASK) || (addr == acms_pkg::OFS_DATA)
                || (addr == acms_pkg::OFS_CALIB);
    endfunction

    // Tells whether a mode code requests a calibration
    function automatic logic isCalCode(input logic [1:0] code);
        isCalCode = (code != acms_pkg::MODE_NORMAL);
    endfunction

    // Zero-wait bus; errors on unmapped offsets
    always_comb
    begin
        pready    = 1'b1;
        pslverr   = psel && penable && !isMapped(paddr);
        wrAccess  = psel && penable && pwrite && isMapped(paddr);
        setupRead = psel && !penable && !pwrite;
    end

    // A calibration starts when software writes a nonzero mode while idle
    always_comb
    begin
        calStart = wrAccess && (paddr == acms_pkg::OFS_CTRL) && (state_reg == acms_pkg::ST_RUN)
                && isCalCode(pwdata[acms_pkg::CTRL_MODE_LSB +: 2]);
    end

    // Output period from the notch select, in master clocks
    always_comb
    begin
        case (notch_reg)
            2'h0:    notchDiv = NOTCH_DIV_0[15:0]; // [R11] [R12]
            2'h1:    notchDiv = NOTCH_DIV_1[15:0];
            2'h2:    notchDiv = NOTCH_DIV_2[15:0];
            default: notchDiv = NOTCH_DIV_3[15:0];
        endcase
    end

    // Input sample divisor from the gain code
    always_comb
    begin
        case (gain_reg)
            acms_pkg::GAIN_X1: sampleDiv = acms_pkg::SAMPLE_DIV_X1; // [R14] [R13]
            acms_pkg::GAIN_X2: sampleDiv = acms_pkg::SAMPLE_DIV_X2;
            default:           sampleDiv = acms_pkg::SAMPLE_DIV_HI;
        endcase
    end

    // Output period timer, restarted so a calibration counts whole periods
    acms_rate_div u_out_div
    (
        .mclk    (mclk),
        .reset_n (reset_n),
        .restart (calStart),
        .divisor (notchDiv),
        .tick    (outTick)
    );

    // Continuous input sampling timer
    acms_rate_div u_smp_div
    (
        .mclk    (mclk),
        .reset_n (reset_n),
        .restart (1'b0),
        .divisor (sampleDiv),
        .tick    (sampleTick)
    );

    // Phase lengths for the running calibration code
    always_comb
    begin
        case (calCode_reg)
            acms_pkg::MODE_SELF_CAL:
            begin
                calTicks  = acms_pkg::CAL_TICKS_SELF;  // [R6]
                drdyTicks = acms_pkg::DATA_READY_N_TICKS_SELF;
            end
            default:
            begin
                calTicks  = acms_pkg::CAL_TICKS_SYS;   // [R7] [R8]
                drdyTicks = acms_pkg::DATA_READY_N_TICKS_SYS;
            end
        endcase
    end

    // Phase end conditions
    always_comb
    begin
        calEnd     = (state_reg == acms_pkg::ST_CAL) && outTick && (tick_reg == calTicks - 4'h1);
        convEnd    = (state_reg == acms_pkg::ST_CONV) && outTick
                  && (tick_reg == drdyTicks - 4'h1);
        pipeEnd    = (state_reg == acms_pkg::ST_PIPE)
                  && (pipe_reg == acms_pkg::PIPE_W'(acms_pkg::PIPE_CYCLES - 1));
        zsPhaseEnd = (state_reg == acms_pkg::ST_CAL) && outTick
                  && (calCode_reg == acms_pkg::MODE_SELF_CAL)
                  && (tick_reg == acms_pkg::ZS_PHASE_TICKS - 4'h1);
        newResult  = ((state_reg == acms_pkg::ST_RUN) && outTick) || pipeEnd;
    end

    // Sequencer next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            acms_pkg::ST_RUN:
            begin
                if (calStart)
                begin
                    state_next = acms_pkg::ST_CAL;
                end
            end
            acms_pkg::ST_CAL:
            begin
                if (calEnd)
                begin
                    state_next = acms_pkg::ST_CONV; // [R2]
                end
            end
            acms_pkg::ST_CONV:
            begin
                if (convEnd)
                begin
                    state_next = acms_pkg::ST_PIPE; // [R5]
                end
            end
            acms_pkg::ST_PIPE:
            begin
                if (pipeEnd)
                begin
                    state_next = acms_pkg::ST_RUN;
                end
            end
            default:
            begin
                state_next = acms_pkg::ST_RUN;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= acms_pkg::ST_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Counts output periods from calibration start through the conversion
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_reg <= 4'h0;
        end
        else if (calStart)
        begin
            tick_reg <= 4'h0;
        end
        else if (((state_reg == acms_pkg::ST_CAL) || (state_reg == acms_pkg::ST_CONV)) && outTick)
        begin
            tick_reg <= tick_reg + 4'h1;
        end
    end

    // Counts the pipeline delay after the first conversion
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pipe_reg <= '0;
        end
        else if (state_reg != acms_pkg::ST_PIPE)
        begin
            pipe_reg <= '0;
        end
        else
        begin
            pipe_reg <= pipe_reg + acms_pkg::PIPE_W'(1); // [R5]
        end
    end

    // Mode bits: written by software, cleared when calibration finishes
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_reg    <= acms_pkg::MODE_NORMAL;
            calCode_reg <= acms_pkg::MODE_NORMAL;
        end
        else if (calStart)
        begin
            mode_reg    <= pwdata[acms_pkg::CTRL_MODE_LSB +: 2];
            calCode_reg <= pwdata[acms_pkg::CTRL_MODE_LSB +: 2];
        end
        else if (calEnd)
        begin
            mode_reg <= acms_pkg::MODE_NORMAL; // [R3]
        end
    end

    // Notch select, gain and mask registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            notch_reg <= acms_pkg::CTRL_RESET[acms_pkg::CTRL_NOTCH_LSB +: 2];
            gain_reg  <= acms_pkg::CTRL_RESET[acms_pkg::CTRL_GAIN_LSB +: 2];
            mask_reg  <= acms_pkg::MASK_RESET;
        end
        else if (wrAccess && (paddr == acms_pkg::OFS_CTRL))
        begin
            notch_reg <= pwdata[acms_pkg::CTRL_NOTCH_LSB +: 2]; // [R11]
            gain_reg  <= pwdata[acms_pkg::CTRL_GAIN_LSB +: 2];  // [R13]
        end
        else if (wrAccess && (paddr == acms_pkg::OFS_MASK))
        begin
            mask_reg <= pwdata[acms_pkg::EVT_W-1:0];
        end
    end

    // Calibration coefficients caught at the end of each phase
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            offset_reg <= '0;
            full_reg   <= '0;
        end
        else if (zsPhaseEnd || (calEnd && (calCode_reg == acms_pkg::MODE_ZS_SYS)))
        begin
            offset_reg <= filterWord; // [R6] [R7]
        end
        else if (calEnd && (calCode_reg != acms_pkg::MODE_ZS_SYS))
        begin
            full_reg <= filterWord; // [R6] [R8]
        end
    end

    // Analog phase controls for the front end
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            zs_reg <= 1'b0;
            fs_reg <= 1'b0;
        end
        else if (calStart)
        begin
            zs_reg <= (pwdata[acms_pkg::CTRL_MODE_LSB +: 2] != acms_pkg::MODE_FS_SYS);
            fs_reg <= (pwdata[acms_pkg::CTRL_MODE_LSB +: 2] == acms_pkg::MODE_FS_SYS);
        end
        else if (zsPhaseEnd)
        begin
            zs_reg <= 1'b0;
            fs_reg <= 1'b1;
        end
        else if (calEnd)
        begin
            zs_reg <= 1'b0;
            fs_reg <= 1'b0;
        end
    end

    // Output register: refreshed each period, or after the pipeline delay
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            result_reg <= '0;
        end
        else if (newResult)
        begin
            result_reg <= filterWord - offset_reg; // [R9] [R2]
        end
    end

    // Data-ready: low on a fresh result, high when a DATA read is set up or on calibration
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            drdyN_reg <= 1'b1;
        end
        else if (newResult)
        begin
            drdyN_reg <= 1'b0; // [R1]
        end
        else if (calStart || (state_reg != acms_pkg::ST_RUN))
        begin
            drdyN_reg <= 1'b1; // [R16]
        end
        else if (setupRead && (paddr == acms_pkg::OFS_DATA))
        begin
            drdyN_reg <= 1'b1;
        end
    end

    // Events for the status register
    always_comb
    begin
        evtSet                          = '0;
        evtSet[acms_pkg::EVT_DATA_RDY]  = newResult;
        evtSet[acms_pkg::EVT_CAL_DONE]  = calEnd; // [R3]
    end

    // Sticky status; cleared at the setup edge where read data is caught, so no event is lost
    acms_irq_status u_irq
    (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .evtSet     (evtSet),
        .rdClear    (setupRead && (paddr == acms_pkg::OFS_STATUS)),
        .maskVal    (mask_reg),
        .status_reg (status_reg),
        .irq        (irq)
    );

    // Read data captured in the setup cycle
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_reg <= 32'h00000000;
        end
        else if (setupRead)
        begin
            case (paddr)
                acms_pkg::OFS_CTRL:   prdata_reg <= {26'h0000000, gain_reg, notch_reg, mode_reg};
                acms_pkg::OFS_STATUS: prdata_reg <= {30'h00000000, status_reg};
                acms_pkg::OFS_MASK:   prdata_reg <= {30'h00000000, mask_reg};
                acms_pkg::OFS_DATA:   prdata_reg <= {16'h0000, result_reg};
                acms_pkg::OFS_CALIB:  prdata_reg <= {full_reg, offset_reg};
                default:              prdata_reg <= 32'h00000000;
            endcase
        end
    end

    // Outputs driven here, all registered except sampleStrobe, which is decoded from the sample counter
    always_comb
    begin
        prdata       = prdata_reg;
        data_ready_n = drdyN_reg;
        sampleStrobe = sampleTick;
        gainCode     = gain_reg;
        zeroScale    = zs_reg;
        fullScale    = fs_reg;
    end

endmodule
`default_nettype wire

// ===== bench/acms_seq_sva.sv
`timescale 1ns/10ps
`default_nettype none
module acms_seq_sva
#(
    parameter int unsigned NOTCH_DIV_0 = 20,
    parameter int unsigned NOTCH_DIV_1 = 16,
    parameter int unsigned NOTCH_DIV_2 = 12,
    parameter int unsigned NOTCH_DIV_3 = 8
)
(
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        data_ready_n,
    input wire logic [1:0]  gainCode,
    input wire logic        zeroScale,
    input wire logic        fullScale
);
    logic        ctrlWr;
    logic [31:0] per;
    logic [1:0]  notch_reg;
    logic [31:0] zsCnt_reg;
    logic [31:0] fsCnt_reg;
    logic [31:0] waitCnt_reg;
    logic        calPrev_reg;
    logic        waiting_reg;

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Notch select and output period as last written
    assign ctrlWr = psel && penable && pwrite && (paddr == acms_pkg::OFS_CTRL);
    assign per = (notch_reg == 2'h0) ? NOTCH_DIV_0 : (notch_reg == 2'h1) ? NOTCH_DIV_1 :
                 (notch_reg == 2'h2) ? NOTCH_DIV_2 : NOTCH_DIV_3;

    // Phase lengths and the wait from end of calibration to fresh data
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            notch_reg   <= 2'h0;
            zsCnt_reg   <= 32'h0;
            fsCnt_reg   <= 32'h0;
            calPrev_reg <= 1'b0;
            waiting_reg <= 1'b0;
            waitCnt_reg <= 32'h0;
        end
        else
        begin
            if (ctrlWr)
                notch_reg <= pwdata[3:2];
            zsCnt_reg   <= zeroScale ? zsCnt_reg + 32'h1 : 32'h0;
            fsCnt_reg   <= fullScale ? fsCnt_reg + 32'h1 : 32'h0;
            calPrev_reg <= zeroScale || fullScale;
            if (calPrev_reg && !(zeroScale || fullScale))
            begin
                waiting_reg <= 1'b1;
                waitCnt_reg <= 32'h1;
            end
            else if (!data_ready_n)
                waiting_reg <= 1'b0;
            else if (waiting_reg)
                waitCnt_reg <= waitCnt_reg + 32'h1;
        end
    end

    a_bus_ready: assert property (pready) else $error("pready low");
    a_slverr_map: assert property (psel && penable |-> pslverr ==
        !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})) else $error("pslverr wrong");
    a_phase_excl: assert property (!(zeroScale && fullScale)) else $error("both phases on");
    a_data_ready_n_quiet: assert property ((zeroScale || fullScale) |-> data_ready_n)
        else $error("data ready during calibration");
    a_zs_length: assert property ($fell(zeroScale) |-> zsCnt_reg == 3 * per)
        else $error("zero-scale phase length");
    a_fs_length: assert property ($fell(fullScale) |-> fsCnt_reg == 3 * per)
        else $error("full-scale phase length");
    a_data_ready_n_early: assert property ($fell(data_ready_n) && waiting_reg |->
        waitCnt_reg >= per + 1998) else $error("data ready too early");
    a_data_ready_n_late: assert property (waiting_reg |-> waitCnt_reg <= 3 * per + 2002)
        else $error("data ready too late");
    a_gain_load: assert property (ctrlWr |=> gainCode == $past(pwdata[5:4]))
        else $error("gain not loaded");

    c_zs_run: cover property ($rose(zeroScale));
    c_fs_run: cover property ($rose(fullScale));
    c_bad_addr: cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// ===== bench/acms_filter_src.sv
`timescale 1ns/10ps
`default_nettype none
module acms_filter_src
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [15:0] level,
    output var  logic [15:0] filterWord
);
    // Filter word follows the requested level a cycle late; junk while in reset
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            filterWord <= 16'hA5C3;
        else
            filterWord <= level;
    end
endmodule
`default_nettype wire

// ===== bench/adc_calibration_mode_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adc_calibration_mode_sequencer_tb;
    logic        mclk, reset_n, psel, penable, pwrite, slv;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, data_ready_n, sampleStrobe, zeroScale, fullScale, irq;
    logic [1:0]  gainCode;
    logic [15:0] filterWord, level, off;
    int          errors, check_count, cyc, t0, n;
    int          per[4] = '{20, 16, 12, 8};
    int          dv[4] = '{64, 32, 8, 8};

    acms_sequencer #(.NOTCH_DIV_0(20), .NOTCH_DIV_1(16), .NOTCH_DIV_2(12), .NOTCH_DIV_3(8)) i_dut
    (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
     .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
     .filterWord(filterWord), .data_ready_n(data_ready_n), .sampleStrobe(sampleStrobe),
     .gainCode(gainCode), .zeroScale(zeroScale), .fullScale(fullScale), .irq(irq));
    acms_filter_src i_src (.mclk(mclk), .reset_n(reset_n), .level(level), .filterWord(filterWord));

    // Clock and cycle count
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;

    task automatic close_out();
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp);
        check_count++;
        if (got < exp - 1 || got > exp + 1)
        begin
            errors++;
            $display("CHECK FAILED %0t took %0d expected %0d", $time, got, exp);
        end
    endtask

    // One APB transfer held until pready; psel alone selects the slave
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // Wait for irq (0), data ready (1) or sample strobe (2) to reach a level
    task automatic waitsig(input int s, input logic v);
        logic cur;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
            cur = (s == 0) ? irq : (s == 1) ? data_ready_n : sampleStrobe;
        end
        while (cur !== v && n < 5000);
        if (n >= 5000)
            chk(32'h0, 32'h1);
    endtask

    // Main sequence
    initial
    begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        level = 16'h1234;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        apb(1'b0, acms_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, acms_pkg::OFS_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({slv, rd[30:0]}, 32'h80000000);
        apb(1'b0, acms_pkg::OFS_CALIB, 32'h0);
        off = rd[15:0];
        // Update period for every notch code
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, acms_pkg::OFS_CTRL, 32'(s << 2));
            waitsig(1, 1'b0);
            apb(1'b0, acms_pkg::OFS_DATA, 32'h0);
            waitsig(1, 1'b0);
            t0 = cyc;
            apb(1'b0, acms_pkg::OFS_DATA, 32'h0);
            chk(rd[15:0], level - off);
            waitsig(1, 1'b0);
            chk(cyc - t0, per[s]);
        end
        // Interrupt masked, unmasked, then armed for calibration done only
        chk(irq, 1'b0);
        apb(1'b1, acms_pkg::OFS_MASK, 32'h1);
        apb(1'b0, acms_pkg::OFS_MASK, 32'h0);
        chk(irq, 1'b1);
        apb(1'b1, acms_pkg::OFS_MASK, 32'h2);
        apb(1'b0, acms_pkg::OFS_MASK, 32'h0);
        chk({rd[1:0], irq}, 32'h4);
        // Gain codes and input sample spacing
        for (int g = 0; g < 4; g++)
        begin
            apb(1'b1, acms_pkg::OFS_CTRL, 32'((g << 4) + 12));
            chk(gainCode, 32'(g));
            waitsig(2, 1'b1);
            t0 = cyc;
            waitsig(2, 1'b1);
            chk(cyc - t0, dv[g]);
        end
        // Each calibration mode; a mode change is refused mid-run
        for (int m = 1; m < 4; m++)
        begin
            apb(1'b1, acms_pkg::OFS_CTRL, 32'(12 + m));
            t0 = cyc;
            if (m == 3)
            begin
                apb(1'b1, acms_pkg::OFS_CTRL, 32'hD);
                apb(1'b0, acms_pkg::OFS_CTRL, 32'h0);
                chk(rd[1:0], 2'h3);
            end
            waitsig(0, 1'b1);
            near(cyc - t0, (m == 1) ? 48 : 24);
            chk(data_ready_n, 1'b1);
            apb(1'b0, acms_pkg::OFS_CTRL, 32'h0);
            chk(rd[1:0], 2'h0);
            if (m < 3)
                off = level;
            level = level + 16'h0111;
            waitsig(1, 1'b0);
            near(cyc - t0, (m == 1) ? 2072 : 2032);
            apb(1'b0, acms_pkg::OFS_STATUS, 32'h0);
            chk({rd[1:0], irq}, 32'h6);
            apb(1'b0, acms_pkg::OFS_DATA, 32'h0);
            chk({data_ready_n, rd[15:0]}, {15'h0, 1'b1, level - off});
        end
        apb(1'b0, acms_pkg::OFS_CALIB, 32'h0);
        chk(rd, 32'h14561345);
        close_out();
    end

    // Watchdog
    initial
    begin
        #600000;
        errors++;
        close_out();
    end
endmodule

bind acms_sequencer acms_seq_sva #(.NOTCH_DIV_0(NOTCH_DIV_0), .NOTCH_DIV_1(NOTCH_DIV_1),
    .NOTCH_DIV_2(NOTCH_DIV_2), .NOTCH_DIV_3(NOTCH_DIV_3)) i_sva
    (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
     .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
     .data_ready_n(data_ready_n), .gainCode(gainCode), .zeroScale(zeroScale),
     .fullScale(fullScale));
`default_nettype wire
